// ==== hw/som_mode_selector.v ====
// Purpose: Selects the drive operation mode at startup and gates
//          later changes among External, panel and network modes
// Assumes: All inputs synchronous to ref_clk_in
// Notes: Avalon-MM slave with waitrequest, one word per register
// Notes on behaviour
// - Priority: setting, stop, net/ext, net/panel, panel/ext, startup
// - Evaluate startup on power-on, restore and reset
// - Mode settings writable whatever write selection says
// - Startup 0, mode 0: External, three-way
// - No direct panel to network change outside startup 10
// - Mode 1: panel fixed always
// - Startup 0, mode 2: External, External/network
// - Mode 2 startup 0/1: never enter panel
// - Modes 3, 4: combined, no changes
// - Startup 0, mode 6: three-way while running
// - Mode 7: stop on three-way, off forced External
// - Startup 1: network; mode 7 follows stop input
// - Startup 10: network, panel/network; mode 7 External
// - Startup 10, mode 0: panel/network only stopped
// - Startup 10, mode 2: network fixed
// - Startup 10, mode 6: panel/network while running
// - Startup 10, modes 0, 6: only key or net/panel input
// - Net/panel input: on panel, off network
// - Net/ext input: on network, off External
// - Panel/ext input: off panel, on External
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "som_defines.vh"

module som_mode_selector #(
    parameter MODE_W = 2
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire output_stop_input_in,
    input wire net_panel_switch_input_in,
    input wire net_external_switch_input_in,
    input wire panel_external_switch_input_in,
    input wire panel_mode_key_in,
    input wire motor_running_in,
    input wire power_restore_in,
    output reg [MODE_W-1:0] op_mode_out,
    output reg refused_out
);

    // ======================================================
    // Mode codes
    localparam [MODE_W-1:0] M_EXT = 2'h0;
    localparam [MODE_W-1:0] M_PU = 2'h1;
    localparam [MODE_W-1:0] M_NET = 2'h2;
    localparam [MODE_W-1:0] M_CMB = 2'h3;

    // ======================================================
    // State
    reg [2:0] om_r;
    reg [3:0] st_r;
    reg [1:0] pw_r;
    reg [2:0] asg_r;
    reg [MODE_W-1:0] cmd_tgt_r;
    reg cmd_go_r;
    reg eval_r;
    reg [MODE_W-1:0] mode_nxt;
    reg ref_set;
    reg [MODE_W-1:0] lvl_tgt;
    reg lvl_vld;
    reg [MODE_W-1:0] ev_tgt;
    reg ev_vld;

    wire bus_req = avs_read_in | avs_write_in;
    wire wr_now = avs_write_in & ~avs_waitrequest_out;
    wire wr_cfg = wr_now & (avs_address_in == `SOM_OFS_CFG);
    wire wr_asg = wr_now & (avs_address_in == `SOM_OFS_ASG);
    wire wr_cmd = wr_now & (avs_address_in == `SOM_OFS_CMD);
    wire wr_sts = wr_now & (avs_address_in == `SOM_OFS_STS);

    wire st10 = (st_r == `SOM_ST_10);
    wire om_fixed = (om_r == `SOM_OM_1) | (om_r == `SOM_OM_3) |
                    (om_r == `SOM_OM_4);
    wire force_ext = (om_r == `SOM_OM_7) & ~output_stop_input_in;
    // Under startup 10 with modes 0 and 6 only two triggers count
    wire lim10 = st10 & ((om_r == `SOM_OM_0) | (om_r == `SOM_OM_6));

    // ======================================================
    // Startup mode for the current settings
    function [MODE_W-1:0] som_start;
        input [2:0] om;
        input [3:0] st;
        input stop;
        begin
            if (om == `SOM_OM_1)
            begin
                som_start = M_PU;
            end
            else if ((om == `SOM_OM_3) || (om == `SOM_OM_4))
            begin
                som_start = M_CMB;
            end
            else if (om == `SOM_OM_7)
            begin
                som_start = ((st == `SOM_ST_1) && stop) ? M_NET : M_EXT;
            end
            else if ((st == `SOM_ST_1) || (st == `SOM_ST_10))
            begin
                som_start = M_NET;
            end
            else
            begin
                som_start = M_EXT;
            end
        end
    endfunction

    // ======================================================
    // Whether a change from cur to tgt is permitted
    function som_allow;
        input [2:0] om;
        input is10;
        input stop;
        input run;
        input [MODE_W-1:0] cur;
        input [MODE_W-1:0] tgt;
        reg pn;
        reg ext_in;
        begin
            pn = ((cur == M_PU) && (tgt == M_NET)) ||
                 ((cur == M_NET) && (tgt == M_PU));
            ext_in = (cur == M_EXT) || (tgt == M_EXT);
            if ((tgt == cur) || (tgt == M_CMB) || (cur == M_CMB))
            begin
                som_allow = 1'b0;
            end
            else if ((om == `SOM_OM_1) || (om == `SOM_OM_3) ||
                     (om == `SOM_OM_4))
            begin
                som_allow = 1'b0;
            end
            else if ((om == `SOM_OM_7) && !stop)
            begin
                som_allow = (tgt == M_EXT);
            end
            else if (is10 && (om == `SOM_OM_0))
            begin
                som_allow = pn & ~run;
            end
            else if (is10 && (om == `SOM_OM_6))
            begin
                som_allow = pn;
            end
            else if (is10 && (om == `SOM_OM_2))
            begin
                som_allow = 1'b0;
            end
            else if (om == `SOM_OM_2)
            begin
                som_allow = (tgt != M_PU) && (cur != M_PU) && ext_in;
            end
            else if (om == `SOM_OM_6)
            begin
                som_allow = ~pn;
            end
            else
            begin
                som_allow = ~pn & ~run;
            end
        end
    endfunction

    // ======================================================
    // Level requests from the switch inputs, in priority order
    always @*
    begin
        lvl_vld = 1'b0;
        lvl_tgt = M_EXT;
        if (!lim10 && asg_r[`SOM_ASG_NE_BIT])
        begin
            lvl_vld = 1'b1;
            lvl_tgt = net_external_switch_input_in ? M_NET : M_EXT;
        end
        else if (asg_r[`SOM_ASG_NP_BIT])
        begin
            lvl_vld = 1'b1;
            lvl_tgt = net_panel_switch_input_in ? M_PU : M_NET;
        end
        else if (!lim10 && asg_r[`SOM_ASG_PE_BIT])
        begin
            lvl_vld = 1'b1;
            lvl_tgt = panel_external_switch_input_in ? M_EXT : M_PU;
        end
    end

    // ======================================================
    // Event requests from the panel key or software
    always @*
    begin
        ev_vld = 1'b0;
        ev_tgt = op_mode_out;
        if (panel_mode_key_in)
        begin
            ev_vld = 1'b1;
            if (lim10)
            begin
                ev_tgt = (op_mode_out == M_PU) ? M_NET : M_PU;
            end
            else
            begin
                ev_tgt = (op_mode_out == M_EXT) ? M_PU : M_EXT;
            end
        end
        else if (cmd_go_r && !lim10)
        begin
            // Software is not a trigger under startup 10 with modes 0 and 6
            ev_vld = 1'b1;
            ev_tgt = cmd_tgt_r;
        end
    end

    // ======================================================
    // Next mode
    always @*
    begin
        mode_nxt = op_mode_out;
        ref_set = 1'b0;
        if (eval_r)
        begin
            mode_nxt = som_start(om_r, st_r, output_stop_input_in);
        end
        else if (force_ext)
        begin
            mode_nxt = M_EXT;
        end
        else if (om_fixed)
        begin
            mode_nxt = op_mode_out;
        end
        else if (lvl_vld)
        begin
            // Levels stand over key presses; a refused level just waits
            if (som_allow(om_r, st10, output_stop_input_in,
                          motor_running_in, op_mode_out, lvl_tgt))
            begin
                mode_nxt = lvl_tgt;
            end
        end
        else if (ev_vld && (ev_tgt != op_mode_out))
        begin
            if (som_allow(om_r, st10, output_stop_input_in,
                          motor_running_in, op_mode_out, ev_tgt))
            begin
                mode_nxt = ev_tgt;
            end
            else
            begin
                ref_set = 1'b1;
            end
        end
        if (ev_vld && om_fixed && !eval_r)
        begin
            ref_set = 1'b1;
        end
    end

    // ======================================================
    // Mode register and evaluation trigger
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            op_mode_out <= M_EXT;
            eval_r <= 1'b1;
            refused_out <= 1'b0;
        end
        else
        begin
            op_mode_out <= mode_nxt;
            eval_r <= power_restore_in |
                      (wr_cmd & avs_writedata_in[`SOM_CMD_EVAL_BIT]);
            // Set wins over a clear in the same cycle
            if (ref_set)
            begin
                refused_out <= 1'b1;
            end
            else if (wr_sts && avs_writedata_in[`SOM_STS_REF_BIT])
            begin
                refused_out <= 1'b0;
            end
        end
    end

    // ======================================================
    // Register writes
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            om_r <= `SOM_RST_OM;
            st_r <= `SOM_RST_ST;
            pw_r <= `SOM_RST_PW;
            asg_r <= `SOM_RST_ASG;
            cmd_tgt_r <= M_EXT;
            cmd_go_r <= 1'b0;
        end
        else
        begin
            cmd_go_r <= wr_cmd & avs_writedata_in[`SOM_CMD_GO_BIT];
            if (wr_cfg)
            begin
                // Write selection is kept but never blocks these fields
                om_r <= avs_writedata_in[`SOM_CFG_OM_HI:`SOM_CFG_OM_LO];
                st_r <= avs_writedata_in[`SOM_CFG_ST_HI:`SOM_CFG_ST_LO];
                pw_r <= avs_writedata_in[`SOM_CFG_PW_HI:`SOM_CFG_PW_LO];
            end
            if (wr_asg)
            begin
                asg_r <= avs_writedata_in[`SOM_ASG_PE_BIT:`SOM_ASG_NE_BIT];
            end
            if (wr_cmd)
            begin
                cmd_tgt_r <=
                    avs_writedata_in[`SOM_CMD_TGT_HI:`SOM_CMD_TGT_LO];
            end
        end
    end

    // ======================================================
    // Bus answer: one wait cycle, then a single ready cycle
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0;
        end
        else
        begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out)
            begin
                case (avs_address_in)
                `SOM_OFS_CFG:
                begin
                    avs_readdata_out <= {22'h0, pw_r, st_r, 1'b0, om_r};
                end
                `SOM_OFS_ASG:
                begin
                    avs_readdata_out <= {29'h0, asg_r};
                end
                `SOM_OFS_CMD:
                begin
                    avs_readdata_out <= {30'h0, cmd_tgt_r};
                end
                `SOM_OFS_STS:
                begin
                    avs_readdata_out <= {27'h0, refused_out, 2'h0,
                                         op_mode_out};
                end
                default:
                begin
                    avs_readdata_out <= 32'h0;
                end
                endcase
            end
        end
    end

endmodule // som_mode_selector

// ==== hw/som_defines.vh ====
// Purpose: Named constants for the startup operation mode selector
// Assumes: Byte addresses on a 4-bit Avalon-MM address
// Notes: Definitions only
`ifndef SOM_DEFINES_VH
`define SOM_DEFINES_VH

// ==========================================================
// Register byte offsets
`define SOM_OFS_CFG 4'h0
`define SOM_OFS_ASG 4'h4
`define SOM_OFS_CMD 4'h8
`define SOM_OFS_STS 4'hC

// ==========================================================
// Field positions
`define SOM_CFG_OM_LO 0
`define SOM_CFG_OM_HI 2
`define SOM_CFG_ST_LO 4
`define SOM_CFG_ST_HI 7
`define SOM_CFG_PW_LO 8
`define SOM_CFG_PW_HI 9
`define SOM_ASG_NE_BIT 0
`define SOM_ASG_NP_BIT 1
`define SOM_ASG_PE_BIT 2
`define SOM_CMD_TGT_LO 0
`define SOM_CMD_TGT_HI 1
`define SOM_CMD_GO_BIT 4
`define SOM_CMD_EVAL_BIT 8
`define SOM_STS_REF_BIT 4

// ==========================================================
// Operation mode settings
`define SOM_OM_0 3'h0
`define SOM_OM_1 3'h1
`define SOM_OM_2 3'h2
`define SOM_OM_3 3'h3
`define SOM_OM_4 3'h4
`define SOM_OM_6 3'h6
`define SOM_OM_7 3'h7

// ==========================================================
// Startup mode settings
`define SOM_ST_0 4'h0
`define SOM_ST_1 4'h1
`define SOM_ST_10 4'hA

// ==========================================================
// Reset values
`define SOM_RST_OM 3'h0
`define SOM_RST_ST 4'h0
`define SOM_RST_PW 2'h0
`define SOM_RST_ASG 3'h0

`endif

// ==== sim/som_terminal_model.sv ====
// Purpose: Terminal inputs and panel key facing the mode selector
// Assumes: Bench requests levels and key presses after a clock edge
// Notes: Every pin changes only just after a rising edge
`timescale 1ns/1ps
module som_terminal_model (
    input wire ref_clk_in,
    input wire [3:0] level_in,
    input wire key_req_in,
    output reg output_stop_input_out = 1'b0,
    output reg net_external_switch_input_out = 1'b0,
    output reg net_panel_switch_input_out = 1'b0,
    output reg panel_external_switch_input_out = 1'b0,
    output reg panel_mode_key_out = 1'b0
);
// ==========================================================
// Pins
always @(posedge ref_clk_in)
begin
    output_stop_input_out <= level_in[3];
    net_external_switch_input_out <= level_in[2];
    net_panel_switch_input_out <= level_in[1];
    panel_external_switch_input_out <= level_in[0];
    // One-cycle press; a held key would look like many presses
    panel_mode_key_out <= key_req_in;
end
endmodule // som_terminal_model

// ==== sim/som_mode_selector_assertions.sv ====
// Purpose: Port checks for the mode selector
// Assumes: Settings are tracked from bus writes
// Notes: Holds are judged only outside evaluation windows
`timescale 1ns/1ps
module som_mode_selector_assertions #(
    parameter MODE_W = 2
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire avs_waitrequest_out,
    input wire output_stop_input_in,
    input wire panel_mode_key_in,
    input wire power_restore_in,
    input wire [MODE_W-1:0] op_mode_out,
    input wire refused_out
);
// ==========================================================
// Helpers
reg [2:0] om_r;
reg [3:0] st_r;
reg [2:0] ev_r;
wire wr_ok = avs_write_in && !avs_waitrequest_out;
wire ev_now = power_restore_in ||
    (wr_ok && avs_address_in == 4'h8 && avs_writedata_in[8]);
// Three cycles of margin after any evaluation
wire quiet = !ev_now && ev_r == 3'h0;
always @(posedge ref_clk_in)
begin
    if (sys_rst_in)
    begin
        om_r <= 3'h0;
        st_r <= 4'h0;
        ev_r <= 3'h7;
    end
    else
    begin
        ev_r <= {ev_r[1:0], ev_now};
        if (wr_ok && avs_address_in == 4'h0)
        begin
            om_r <= avs_writedata_in[2:0];
            st_r <= avs_writedata_in[7:4];
        end
    end
end
// ==========================================================
// Assertions
default clocking cb @(posedge ref_clk_in);
endclocking
default disable iff (sys_rst_in);
AST_RST_IDLE: assert property (disable iff (1'b0)
    sys_rst_in |=> op_mode_out == 2'h0 && !refused_out)
    else $error("mode or refusal not cleared by reset");
AST_ACCEPT: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle after request");
AST_NO_DIRECT: assert property (
    quiet && st_r != 4'hA && (op_mode_out == 2'h1 || op_mode_out == 2'h2)
    |=> op_mode_out != ~$past(op_mode_out))
    else $error("direct panel network change");
AST_PANEL_HOLD: assert property (
    quiet && om_r == 3'h1 && op_mode_out == 2'h1 |=> op_mode_out == 2'h1)
    else $error("panel mode left under fixed setting");
AST_NO_PANEL: assert property (
    quiet && om_r == 3'h2 && st_r != 4'hA && op_mode_out != 2'h1
    |=> op_mode_out != 2'h1)
    else $error("panel mode entered under mode 2");
AST_COMB_HOLD: assert property (
    quiet && op_mode_out == 2'h3 |=> $stable(op_mode_out))
    else $error("combined mode left without evaluation");
AST_FORCE_EXT: assert property (
    (om_r == 3'h7 && !output_stop_input_in)[*3] |=> op_mode_out == 2'h0)
    else $error("mode 7 with stop off not External");
AST_NET_HOLD: assert property (
    quiet && om_r == 3'h2 && st_r == 4'hA && op_mode_out == 2'h2
    |=> op_mode_out == 2'h2)
    else $error("network mode left under fixed setting");
COV_KEY: cover property (panel_mode_key_in ##1 $changed(op_mode_out));
COV_RESTORE: cover property (power_restore_in);
COV_REFUSE: cover property ($rose(refused_out));
endmodule // som_mode_selector_assertions

bind som_mode_selector som_mode_selector_assertions #(.MODE_W(MODE_W))
    u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_waitrequest_out(avs_waitrequest_out),
    .output_stop_input_in(output_stop_input_in),
    .panel_mode_key_in(panel_mode_key_in),
    .power_restore_in(power_restore_in), .op_mode_out(op_mode_out),
    .refused_out(refused_out));

// ==== sim/test_som_mode_selector.sv ====
// Purpose: Self-checking bench for the mode selector
// Assumes: Bus answers one cycle after a request is taken
// Notes: Status reads are matched against a queue of notes
`timescale 1ns/1ps
module test_som_mode_selector;
reg ref_clk_in = 1'b0;
reg sys_rst_in = 1'b1;
reg [3:0] avs_address_in = 4'h0;
reg avs_read_in = 1'b0;
reg avs_write_in = 1'b0;
reg [31:0] avs_writedata_in = 32'h0;
reg [3:0] lvl = 4'h8;
reg key_req = 1'b0;
reg motor_running_in = 1'b0;
reg power_restore_in = 1'b0;
wire [31:0] avs_readdata_out;
wire avs_waitrequest_out;
wire stop_w, ne_w, np_w, pe_w, key_w;
wire [1:0] op_mode_out;
wire refused_out;
reg [31:0] q[$];
reg [31:0] seed = 32'hE;
reg [2:0] o;
reg [3:0] s;
integer n_errors = 0;
integer tests_run = 0;
integer i;
// ==========================================================
// Design and far side
som_mode_selector dut_u (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .output_stop_input_in(stop_w), .net_panel_switch_input_in(np_w),
    .net_external_switch_input_in(ne_w),
    .panel_external_switch_input_in(pe_w), .panel_mode_key_in(key_w),
    .motor_running_in(motor_running_in),
    .power_restore_in(power_restore_in), .op_mode_out(op_mode_out),
    .refused_out(refused_out));
som_terminal_model term_u (.ref_clk_in(ref_clk_in), .level_in(lvl),
    .key_req_in(key_req), .output_stop_input_out(stop_w),
    .net_external_switch_input_out(ne_w),
    .net_panel_switch_input_out(np_w),
    .panel_external_switch_input_out(pe_w), .panel_mode_key_out(key_w));
initial
begin
    forever #5 ref_clk_in = ~ref_clk_in;
end
// ==========================================================
// Tasks
function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
function [1:0] boot(input [2:0] m, input [3:0] k);
    begin
        boot = (m == 3'h1) ? 2'h1 : (m == 3'h3 || m == 3'h4) ? 2'h3 :
            (m == 3'h7) ? ((k == 4'h1) ? 2'h2 : 2'h0) :
            ((k == 4'h0) ? 2'h0 : 2'h2);
    end
endfunction
task chk(input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    end
endtask
task close_out;
    begin
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
endtask
task bus(input wr, input [3:0] a, input [31:0] d);
    begin
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        @(posedge ref_clk_in);
        while (avs_waitrequest_out !== 1'b0)
            @(posedge ref_clk_in);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    end
endtask
task rd(input [3:0] a, input [31:0] exp);
    begin
        q.push_back(exp);
        bus(1'b0, a, 32'h0);
    end
endtask
task sts(input [1:0] m, input r);
    begin
        repeat (5) @(posedge ref_clk_in);
        rd(4'hC, {27'h0, r, 2'h0, m});
    end
endtask
task cfg(input [2:0] m, input [3:0] k, input [1:0] ev);
    begin
        seed = xs(seed);
        bus(1'b1, 4'h0, {22'h0, seed[1:0], k, 1'b0, m});
        if (ev == 2'h1)
            bus(1'b1, 4'h8, 32'h100);
        if (ev == 2'h2)
        begin
            @(posedge ref_clk_in);
            power_restore_in <= 1'b1;
            @(posedge ref_clk_in);
            power_restore_in <= 1'b0;
        end
    end
endtask
task key;
    begin
        @(posedge ref_clk_in);
        key_req <= 1'b1;
        @(posedge ref_clk_in);
        key_req <= 1'b0;
    end
endtask
// ==========================================================
// Checker of read answers
always @(posedge ref_clk_in)
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
        chk(avs_readdata_out, q.pop_front());
initial
begin
    repeat (5000) @(posedge ref_clk_in);
    n_errors = n_errors + 1;
    close_out;
end
// ==========================================================
// Scenarios
initial
begin
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    sts(2'h0, 1'b0);
    rd(4'h2, 32'h0);
    for (i = 0; i < 21; i = i + 1)
    begin
        o = 3'((i % 7 > 4) ? i % 7 + 1 : i % 7);
        s = (i / 7 == 2) ? 4'hA : 4'(i / 7);
        cfg(o, s, 2'(i % 2 + 1));
        sts(boot(o, s), 1'b0);
        rd(4'h0, {22'h0, seed[1:0], s, 1'b0, o});
    end
    lvl <= 4'h0;
    cfg(3'h7, 4'h1, 2'h1);
    sts(2'h0, 1'b0);
    lvl <= 4'h8;
    cfg(3'h0, 4'h0, 2'h1);
    key;
    sts(2'h1, 1'b0);
    bus(1'b1, 4'h8, 32'h12);
    sts(2'h1, 1'b1);
    bus(1'b1, 4'hC, 32'h10);
    key;
    bus(1'b1, 4'h8, 32'h12);
    sts(2'h2, 1'b0);
    rd(4'h8, 32'h2);
    cfg(3'h2, 4'h0, 2'h2);
    key;
    sts(2'h0, 1'b1);
    bus(1'b1, 4'hC, 32'h10);
    bus(1'b1, 4'h8, 32'h12);
    sts(2'h2, 1'b0);
    cfg(3'h0, 4'hA, 2'h1);
    key;
    sts(2'h1, 1'b0);
    // Software is no trigger under startup 10, mode 0: no change, no refusal
    bus(1'b1, 4'h8, 32'h12);
    sts(2'h1, 1'b0);
    motor_running_in <= 1'b1;
    key;
    sts(2'h1, 1'b1);
    cfg(3'h6, 4'hA, 2'h1);
    key;
    sts(2'h1, 1'b1);
    cfg(3'h6, 4'h0, 2'h2);
    bus(1'b1, 4'h8, 32'h12);
    sts(2'h2, 1'b1);
    motor_running_in <= 1'b0;
    bus(1'b1, 4'hC, 32'h10);
    cfg(3'h2, 4'hA, 2'h1);
    key;
    sts(2'h2, 1'b1);
    bus(1'b1, 4'hC, 32'h10);
    cfg(3'h1, 4'h0, 2'h1);
    key;
    sts(2'h1, 1'b1);
    bus(1'b1, 4'hC, 32'h10);
    cfg(3'h3, 4'h1, 2'h2);
    key;
    sts(2'h3, 1'b1);
    bus(1'b1, 4'hC, 32'h10);
    cfg(3'h0, 4'h0, 2'h1);
    lvl <= 4'hC;
    bus(1'b1, 4'h4, 32'h1);
    sts(2'h2, 1'b0);
    lvl <= 4'h8;
    sts(2'h0, 1'b0);
    cfg(3'h0, 4'hA, 2'h1);
    bus(1'b1, 4'h4, 32'h2);
    lvl <= 4'hA;
    sts(2'h1, 1'b0);
    lvl <= 4'h8;
    sts(2'h2, 1'b0);
    // Assign first: a level left from network would block panel later
    bus(1'b1, 4'h4, 32'h4);
    cfg(3'h0, 4'h0, 2'h1);
    sts(2'h1, 1'b0);
    lvl <= 4'h9;
    sts(2'h0, 1'b0);
    // Assign before raising levels, so panel is never passed through
    bus(1'b1, 4'h4, 32'h7);
    lvl <= 4'hE;
    cfg(3'h7, 4'h0, 2'h0);
    sts(2'h2, 1'b0);
    lvl <= 4'h6;
    sts(2'h0, 1'b0);
    // Let the last answer be compared before the verdict
    repeat (2) @(posedge ref_clk_in);
    chk(q.size(), 32'h0);
    close_out;
end
endmodule // test_som_mode_selector
